//--- logic/efcn_pkg.sv
// package: shared constants and types for endpoint flow control and notify
`default_nettype none
package efcn_pkg;
    localparam int EFCN_EP_W     = 4;                 // endpoint number width
    localparam int EFCN_NUM_EP   = 16;                // endpoints tracked
    localparam int EFCN_VEC_W    = 8;                 // ack vector width
    localparam int EFCN_CNT_W    = 8;                 // buffer count width
    localparam int EFCN_RETRY_W  = 8;                 // retry timer width
    localparam logic [7:0] EFCN_RETRY_SLOTS = 8'h04;  // slots between resends
    localparam logic [7:0] EFCN_RETRY_RST   = 8'h00;  // retry timer after reset

    // handshake result codes
    typedef enum logic [1:0] {
        EFCN_HS_ACK   = 2'b00,
        EFCN_HS_NAK   = 2'b01,
        EFCN_HS_STALL = 2'b10
    } efcn_hs_e;

    // endpoint transfer types
    typedef enum logic [1:0] {
        EFCN_TT_CTRL = 2'b00,
        EFCN_TT_ISO  = 2'b01,
        EFCN_TT_BULK = 2'b10,
        EFCN_TT_INTR = 2'b11
    } efcn_tt_e;

    // token kinds the host schedules
    typedef enum logic [1:0] {
        EFCN_TK_IN   = 2'b00,
        EFCN_TK_OUT  = 2'b01,
        EFCN_TK_HSRQ = 2'b10
    } efcn_tk_e;

    // notifier states
    typedef enum logic [1:0] {
        EFCN_NS_IDLE = 2'b00,
        EFCN_NS_SEND = 2'b01,
        EFCN_NS_WAIT = 2'b10
    } efcn_ns_e;

    // endpoints with a nonzero count of free space or data of at least the max packet count
    function automatic logic efcn_has_room(input logic [7:0] cnt,
                                           input logic [7:0] mps);
        return (cnt != 8'h00) && (cnt >= mps);
    endfunction

    // vector with the low n bits set, saturating at the vector width
    function automatic logic [7:0] efcn_vec(input logic [7:0] n);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (8'(i) < n) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction
endpackage
`default_nettype wire

//--- logic/efcn_link_if.sv
// interface: token, handshake and notification link between host and device
`timescale 1ns/1ps
`default_nettype none
interface efcn_link_if;
    import efcn_pkg::*;
    logic                 tok_valid;   // host token strobe
    efcn_tk_e             tok_kind;    // in, out or handshake request
    logic [EFCN_EP_W-1:0] tok_ep;      // addressed endpoint
    logic [7:0]           tok_npkt;    // packets offered in out data phase
    logic                 cfg_event;   // configuration event pulse
    logic                 device_notify_time_slot; // slot open, one cycle
    logic                 rsp_valid;   // device answer strobe
    logic                 rsp_is_data; // in: data rather than handshake
    efcn_hs_e             rsp_code;    // handshake_result_code
    logic [7:0]           rsp_vec;     // buffer_ack_vector
    logic                 ntf_valid;   // endpoints-ready message strobe
    logic                 ntf_enc;     // message encrypted
    logic [EFCN_NUM_EP-1:0] ntf_eps;   // endpoints reported ready
    logic                 ntf_ack;     // host response to notification

    modport dev (input tok_valid, tok_kind, tok_ep, tok_npkt, cfg_event,
                 device_notify_time_slot, ntf_ack,
                 output rsp_valid, rsp_is_data, rsp_code, rsp_vec,
                 ntf_valid, ntf_enc, ntf_eps);
    modport host (output tok_valid, tok_kind, tok_ep, tok_npkt, cfg_event,
                  device_notify_time_slot, ntf_ack,
                  input rsp_valid, rsp_is_data, rsp_code, rsp_vec,
                  ntf_valid, ntf_enc, ntf_eps);
endinterface
`default_nettype wire

//--- logic/efcn_dev.sv
// device end: endpoint flow control responses and endpoints-ready notifier
`timescale 1ns/1ps
`default_nettype none
module efcn_dev
    import efcn_pkg::*;
#(
    parameter int NUM_EP = EFCN_NUM_EP  // endpoints tracked
) (
    input  wire logic                clk_i,         // protocol engine clock
    input  wire logic                rst_n_i,       // async reset, active low
    efcn_link_if.dev                 link,          // host side of the link
    input  wire logic [NUM_EP-1:0]   ep_enc_i,      // endpoint encrypted
    input  wire logic [NUM_EP*2-1:0] ep_type_i,     // transfer type per ep
    input  wire logic [NUM_EP*8-1:0] ep_mps_i,      // max packet, in packets
    input  wire logic [NUM_EP*8-1:0] ep_level_i,    // in data / out space
    input  wire logic [NUM_EP-1:0]   ep_stall_i,    // endpoint halted
    output logic [NUM_EP-1:0]        ep_fc_o,       // flow-controlled flags
    output logic                     rx_take_o,     // out data accepted
    output logic [7:0]               rx_count_o,    // packets accepted
    output logic                     tx_take_o,     // in data sent
    output logic                     ntf_busy_o     // notification pending
);
    // the link carries one flag per endpoint, so other sizes cannot work
    if (NUM_EP != EFCN_NUM_EP) begin : g_num_ep_chk
        $error("efcn_dev: NUM_EP must match the link width");
    end

    // all state of this end
    typedef struct packed {
        logic [NUM_EP-1:0] fc;        // flow-controlled flag per endpoint
        logic [NUM_EP*2-1:0] last_hs; // last flow control code per endpoint
        efcn_ns_e          ns;        // notifier state
        logic              enc;       // encryption of current message
        logic [NUM_EP-1:0] eps;       // endpoints in current message
        logic [7:0]        retry;     // slots left before resend
        logic              rsp_valid; // answer strobe
        logic              rsp_is_data;
        efcn_hs_e          rsp_code;
        logic [7:0]        rsp_vec;
        logic              ntf_valid;
        logic              rx_take;
        logic [7:0]        rx_count;
        logic              tx_take;
    } efcn_dev_s;

    efcn_dev_s st_r;   // registered state
    efcn_dev_s st_nxt; // next state

    logic [NUM_EP-1:0] ready_plain; // ready, notifiable, unencrypted
    logic [NUM_EP-1:0] ready_enc;   // ready, notifiable, encrypted

    // find endpoints that may be announced, split by encryption
    always_comb begin
        ready_plain = '0;
        ready_enc   = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            // isochronous endpoints never go through notification
            if (st_r.fc[i] && !ep_stall_i[i]
                && ep_type_i[2*i +: 2] != EFCN_TT_ISO
                && efcn_has_room(ep_level_i[8*i +: 8],
                                 ep_mps_i[8*i +: 8])) begin
                if (ep_enc_i[i]) begin
                    ready_enc[i] = 1'b1;
                end else begin
                    ready_plain[i] = 1'b1;
                end
            end
        end
    end

    // next-state logic for responses and the notifier
    always_comb begin
        logic [7:0] lvl;
        logic [7:0] acc;
        lvl    = 8'h00;
        acc    = 8'h00;
        st_nxt = st_r;
        st_nxt.rsp_valid   = 1'b0;
        st_nxt.rsp_is_data = 1'b0;
        st_nxt.ntf_valid   = 1'b0;
        st_nxt.rx_take     = 1'b0;
        st_nxt.tx_take     = 1'b0;

        // host answered: reported endpoints are back in service; a token
        // below may flag one again in this cycle, and that set wins
        if (st_r.ns == EFCN_NS_WAIT && link.ntf_ack) begin
            st_nxt.fc = st_r.fc & ~st_r.eps;
        end

        if (link.tok_valid) begin
            lvl = ep_level_i[8*link.tok_ep +: 8];
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_vec   = 8'h00;
            if (ep_stall_i[link.tok_ep]) begin
                // halted endpoint answers stall, not a flow control event
                st_nxt.rsp_code = EFCN_HS_STALL;
            end else begin
                case (link.tok_kind)
                    EFCN_TK_IN: begin
                        if (lvl != 8'h00) begin
                            st_nxt.rsp_is_data = 1'b1;
                            st_nxt.rsp_code    = EFCN_HS_ACK;
                            st_nxt.tx_take     = 1'b1;
                            st_nxt.fc[link.tok_ep] = 1'b0;
                        end else begin
                            st_nxt.rsp_code = EFCN_HS_NAK;
                            st_nxt.fc[link.tok_ep] = 1'b1;
                            st_nxt.last_hs[2*link.tok_ep +: 2] = EFCN_HS_NAK;
                        end
                    end
                    EFCN_TK_OUT: begin
                        acc = (lvl < link.tok_npkt) ? lvl : link.tok_npkt;
                        st_nxt.rx_take  = (acc != 8'h00);
                        st_nxt.rx_count = acc;
                        if (acc == 8'h00 && link.tok_npkt != 8'h00) begin
                            st_nxt.rsp_code = EFCN_HS_NAK;
                            st_nxt.rsp_vec  = 8'h00;
                            st_nxt.fc[link.tok_ep] = 1'b1;
                            st_nxt.last_hs[2*link.tok_ep +: 2] = EFCN_HS_NAK;
                        end else begin
                            st_nxt.rsp_code = EFCN_HS_ACK;
                            st_nxt.rsp_vec  = efcn_vec(8'(lvl - acc));
                            if (lvl == acc) begin
                                st_nxt.fc[link.tok_ep] = 1'b1;
                                st_nxt.last_hs[2*link.tok_ep +: 2] =
                                    EFCN_HS_ACK;
                            end else begin
                                st_nxt.fc[link.tok_ep] = 1'b0;
                            end
                        end
                    end
                    EFCN_TK_HSRQ: begin
                        // buffering query, also used to resume periodic outs
                        if (lvl == 8'h00 && st_r.fc[link.tok_ep]) begin
                            st_nxt.rsp_code = efcn_hs_e'(
                                st_r.last_hs[2*link.tok_ep +: 2]);
                            st_nxt.rsp_vec  = 8'h00;
                        end else if (lvl == 8'h00) begin
                            st_nxt.rsp_code = EFCN_HS_ACK;
                            st_nxt.fc[link.tok_ep] = 1'b1;
                            st_nxt.last_hs[2*link.tok_ep +: 2] = EFCN_HS_ACK;
                        end else begin
                            st_nxt.rsp_code = EFCN_HS_ACK;
                            st_nxt.rsp_vec  = efcn_vec(lvl);
                            st_nxt.fc[link.tok_ep] = 1'b0;
                        end
                    end
                    default: begin
                        st_nxt.rsp_code = EFCN_HS_STALL;
                    end
                endcase
            end
        end

        // endpoints-ready notifier
        case (st_r.ns)
            EFCN_NS_IDLE: begin
                // plain first; encrypted waits for next message
                if (ready_plain != '0) begin
                    st_nxt.enc = 1'b0;
                    st_nxt.eps = ready_plain;
                    st_nxt.ns  = EFCN_NS_SEND;
                end else if (ready_enc != '0) begin
                    st_nxt.enc = 1'b1;
                    st_nxt.eps = ready_enc;
                    st_nxt.ns  = EFCN_NS_SEND;
                end
            end
            EFCN_NS_SEND: begin
                if (link.device_notify_time_slot) begin
                    st_nxt.ntf_valid = 1'b1;
                    st_nxt.retry     = EFCN_RETRY_SLOTS;
                    st_nxt.ns        = EFCN_NS_WAIT;
                end
            end
            EFCN_NS_WAIT: begin
                if (link.ntf_ack) begin
                    // flags were cleared ahead of the token logic
                    st_nxt.ns = EFCN_NS_IDLE;
                end else if (link.device_notify_time_slot) begin
                    if (st_r.retry <= 8'h01) begin
                        st_nxt.ns = EFCN_NS_SEND;
                    end else begin
                        st_nxt.retry = 8'(st_r.retry - 8'h01);
                    end
                end
            end
            default: begin
                st_nxt.ns = EFCN_NS_IDLE;
            end
        endcase

        // configuration event puts everything back to ready
        if (link.cfg_event) begin
            st_nxt.fc = '0;
            st_nxt.ns = EFCN_NS_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{fc: '0, last_hs: '0, ns: EFCN_NS_IDLE, enc: 1'b0,
                      eps: '0, retry: EFCN_RETRY_RST, rsp_valid: 1'b0,
                      rsp_is_data: 1'b0, rsp_code: EFCN_HS_ACK,
                      rsp_vec: 8'h00, ntf_valid: 1'b0, rx_take: 1'b0,
                      rx_count: 8'h00, tx_take: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.rsp_valid   = st_r.rsp_valid;
    assign link.rsp_is_data = st_r.rsp_is_data;
    assign link.rsp_code    = st_r.rsp_code;
    assign link.rsp_vec     = st_r.rsp_vec;
    assign link.ntf_valid   = st_r.ntf_valid;
    assign link.ntf_enc     = st_r.enc;
    assign link.ntf_eps     = st_r.eps;
    assign ep_fc_o          = st_r.fc;
    assign rx_take_o        = st_r.rx_take;
    assign rx_count_o       = st_r.rx_count;
    assign tx_take_o        = st_r.tx_take;
    assign ntf_busy_o       = (st_r.ns != EFCN_NS_IDLE);
endmodule
`default_nettype wire

//--- logic/efcn_host.sv
// host end: token scheduler with active list and notification answers
`timescale 1ns/1ps
`default_nettype none
module efcn_host
    import efcn_pkg::*;
#(
    parameter int NUM_EP = EFCN_NUM_EP  // endpoints tracked
) (
    input  wire logic              clk_i,       // protocol engine clock
    input  wire logic              rst_n_i,     // async reset, active low
    efcn_link_if.host              link,        // device side of the link
    input  wire logic              req_valid_i, // user token request
    input  wire efcn_tk_e          req_kind_i,  // token kind
    input  wire logic [EFCN_EP_W-1:0] req_ep_i, // endpoint
    input  wire logic [7:0]        req_npkt_i,  // packets for out
    input  wire logic              req_periodic_i, // scheduled service slot
    input  wire logic              cfg_event_i, // configuration event
    input  wire logic              device_notify_time_slot_i, // slot opens
    output logic                   req_ready_o, // request taken
    output logic [NUM_EP-1:0]      active_o,    // endpoints being polled
    output logic                   rsp_valid_o, // answer seen
    output efcn_hs_e               rsp_code_o,  // answer code
    output logic [7:0]             rsp_vec_o,   // answer vector
    output logic                   ntf_seen_o   // notification received
);
    // the link carries one flag per endpoint, so other sizes cannot work
    if (NUM_EP != EFCN_NUM_EP) begin : g_num_ep_chk
        $error("efcn_host: NUM_EP must match the link width");
    end

    // all state of this end
    typedef struct packed {
        logic [NUM_EP-1:0]    active;   // endpoints in service list
        logic                 busy;     // token outstanding
        logic [EFCN_EP_W-1:0] ep;       // endpoint of outstanding token
        logic                 tok_valid;
        efcn_tk_e             tok_kind;
        logic [7:0]           tok_npkt;
        logic                 ntf_ack;
        logic                 rsp_valid;
        efcn_hs_e             rsp_code;
        logic [7:0]           rsp_vec;
        logic                 ntf_seen;
    } efcn_host_s;

    efcn_host_s st_r;   // registered state
    efcn_host_s st_nxt; // next state

    // one token outstanding; inactive endpoints only via periodic or query
    assign req_ready_o = !st_r.busy && req_valid_i &&
        (st_r.active[req_ep_i] || req_periodic_i ||
         req_kind_i == EFCN_TK_HSRQ);

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.tok_valid = 1'b0;
        st_nxt.ntf_ack   = 1'b0;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.ntf_seen  = 1'b0;
        if (req_ready_o) begin
            st_nxt.tok_valid = 1'b1;
            st_nxt.tok_kind  = req_kind_i;
            st_nxt.tok_npkt  = req_npkt_i;
            st_nxt.ep        = req_ep_i;
            st_nxt.busy      = 1'b1;
        end
        if (link.rsp_valid) begin
            st_nxt.busy      = 1'b0;
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_code  = link.rsp_code;
            st_nxt.rsp_vec   = link.rsp_vec;
            // nak or ack with zero vector is flow control
            if (!link.rsp_is_data && (link.rsp_code == EFCN_HS_NAK ||
                (link.rsp_code == EFCN_HS_ACK && link.rsp_vec == 8'h00))) begin
                st_nxt.active[st_r.ep] = 1'b0;
            end else if (link.rsp_code != EFCN_HS_STALL) begin
                st_nxt.active[st_r.ep] = 1'b1;
            end
        end
        if (link.ntf_valid) begin
            st_nxt.ntf_seen = 1'b1;
            st_nxt.ntf_ack  = 1'b1;
            st_nxt.active   = st_nxt.active | link.ntf_eps;
        end
        if (cfg_event_i) begin
            st_nxt.active = '1;
            st_nxt.busy   = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{active: '1, busy: 1'b0, ep: '0, tok_valid: 1'b0,
                      tok_kind: EFCN_TK_IN, tok_npkt: 8'h00, ntf_ack: 1'b0,
                      rsp_valid: 1'b0, rsp_code: EFCN_HS_ACK,
                      rsp_vec: 8'h00, ntf_seen: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.tok_valid = st_r.tok_valid;
    assign link.tok_kind  = st_r.tok_kind;
    assign link.tok_ep    = st_r.ep;
    assign link.tok_npkt  = st_r.tok_npkt;
    assign link.ntf_ack   = st_r.ntf_ack;
    assign link.cfg_event = cfg_event_i;
    assign link.device_notify_time_slot = device_notify_time_slot_i;
    assign active_o       = st_r.active;
    assign rsp_valid_o    = st_r.rsp_valid;
    assign rsp_code_o     = st_r.rsp_code;
    assign rsp_vec_o      = st_r.rsp_vec;
    assign ntf_seen_o     = st_r.ntf_seen;
endmodule
`default_nettype wire

//--- bench/efcn_chk_sva.sv
// checker: link properties between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module efcn_chk
    import efcn_pkg::*;
(
    input  wire logic                   clk_i,       // engine clock
    input  wire logic                   rst_n_i,     // async reset, low
    input  wire logic                   tok_valid,   // token strobe
    input  wire efcn_tk_e               tok_kind,    // token kind
    input  wire logic                   device_notify_time_slot, // slot
    input  wire logic                   rsp_valid,   // answer strobe
    input  wire logic                   rsp_is_data, // data, not handshake
    input  wire efcn_hs_e               rsp_code,    // handshake code
    input  wire logic [7:0]             rsp_vec,     // ack vector
    input  wire logic                   ntf_valid,   // notification strobe
    input  wire logic [EFCN_NUM_EP-1:0] ntf_eps,     // endpoints reported
    input  wire logic                   ntf_ack      // host response
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ntf_in_slot: assert property (ntf_valid
        |-> $past(device_notify_time_slot))
        else $error("notification sent outside a slot");
    a_ntf_host_acks: assert property (ntf_valid |=> ntf_ack)
        else $error("notification not answered by the host");
    a_tok_answered: assert property (rsp_valid |-> $past(tok_valid))
        else $error("answer without a token");
    a_tok_spacing: assert property (tok_valid |=> !tok_valid [*2])
        else $error("second token while one is outstanding");
    a_out_handshake: assert property (
        tok_valid && tok_kind == EFCN_TK_OUT |=> rsp_valid && !rsp_is_data)
        else $error("out token without a handshake");
    // an in endpoint with nothing to send never claims success
    a_in_empty_nak: assert property (rsp_valid && !rsp_is_data &&
        $past(tok_kind) == EFCN_TK_IN |-> rsp_code != EFCN_HS_ACK)
        else $error("in handshake carries ack");
    a_nak_zero_vec: assert property (rsp_valid &&
        rsp_code == EFCN_HS_NAK |-> rsp_vec == 8'h00)
        else $error("nak with non-zero vector");
    // vector is a run of low ones, so a gap means a miscount
    a_vec_low_run: assert property (rsp_valid
        |-> (rsp_vec & (rsp_vec + 8'h01)) == 8'h00)
        else $error("ack vector not a run of low bits");
    a_ntf_has_eps: assert property (ntf_valid |-> ntf_eps != '0)
        else $error("notification lists no endpoint");

    c_notify: cover property (ntf_valid);
    c_nak: cover property (rsp_valid && rsp_code == EFCN_HS_NAK);
    c_ack_full: cover property (rsp_valid && rsp_code == EFCN_HS_ACK &&
        rsp_vec == 8'h00);
endmodule
`default_nettype wire

//--- bench/tb.sv
// testbench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    import efcn_pkg::*;
    logic         clk_i = 1'b0;            // 40 MHz engine clock
    logic         rst_n_i = 1'b0;          // async reset, active low
    logic [15:0]  ep_enc = 16'h0010;       // only ep4 encrypted
    logic [31:0]  ep_type = 32'h0000_0628; // ep1,2,4 bulk, ep5 iso
    // ep1 needs 4 packets and ep4 needs 2 before they count as ready
    logic [127:0] ep_mps = 128'h0101_0101_0101_0101_0101_0102_0101_0401;
    logic [127:0] ep_level = 128'h0800;    // ep1 starts with 8 free
    logic [15:0]  ep_stall = 16'h0000;     // no halted endpoint
    logic         req_valid = 1'b0, req_periodic = 1'b0;
    logic         cfg_event = 1'b0, device_notify_time_slot = 1'b0;
    efcn_tk_e     req_kind = EFCN_TK_IN;
    logic [3:0]   req_ep = 4'h0;
    logic [7:0]   req_npkt = 8'h00;
    logic [15:0]  ep_fc, active;
    logic [7:0]   rx_count, rsp_vec;
    logic         ntf_busy, req_ready, rsp_valid, ntf_seen;
    logic         rx_take, tx_take;        // data moved, one cycle each
    logic [7:0]   n_take = 8'h00;          // data moves counted
    efcn_hs_e     rsp_code;
    int           errors = 0, n_checks = 0;

    always #12.5 clk_i = ~clk_i;

    // the take strobes last one cycle, so they are counted as they pass
    always @(posedge clk_i) begin
        if (rst_n_i) begin
            n_take <= n_take + 8'(rx_take) + 8'(tx_take);
        end
    end

    efcn_link_if link();
    efcn_dev #(.NUM_EP(16)) efcn_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link), .ep_enc_i(ep_enc), .ep_type_i(ep_type),
        .ep_mps_i(ep_mps), .ep_level_i(ep_level), .ep_stall_i(ep_stall),
        .ep_fc_o(ep_fc), .rx_take_o(rx_take), .rx_count_o(rx_count),
        .tx_take_o(tx_take), .ntf_busy_o(ntf_busy));
    efcn_host #(.NUM_EP(16)) efcn_host_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .link(link), .req_valid_i(req_valid),
        .req_kind_i(req_kind), .req_ep_i(req_ep), .req_npkt_i(req_npkt),
        .req_periodic_i(req_periodic), .cfg_event_i(cfg_event),
        .device_notify_time_slot_i(device_notify_time_slot),
        .req_ready_o(req_ready), .active_o(active),
        .rsp_valid_o(rsp_valid), .rsp_code_o(rsp_code),
        .rsp_vec_o(rsp_vec), .ntf_seen_o(ntf_seen));
    efcn_chk efcn_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .tok_valid(link.tok_valid), .tok_kind(link.tok_kind),
        .device_notify_time_slot(link.device_notify_time_slot),
        .rsp_valid(link.rsp_valid),
        .rsp_is_data(link.rsp_is_data), .rsp_code(link.rsp_code),
        .rsp_vec(link.rsp_vec), .ntf_valid(link.ntf_valid),
        .ntf_eps(link.ntf_eps), .ntf_ack(link.ntf_ack));

    // one comparison, counted; unknowns never match
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // set the level of one endpoint at a clock edge
    task automatic lvl(input int ep, input logic [7:0] v);
        @(posedge clk_i);
        ep_level[ep*8 +: 8] <= v;
    endtask

    // one token, held until taken, then its answer compared
    task automatic xfer(input efcn_tk_e k, input logic [3:0] ep,
                        input logic [7:0] n, input efcn_hs_e c,
                        input logic [7:0] v);
        int t;
        t = 0;
        @(posedge clk_i);
        req_valid <= 1'b1;
        req_kind <= k;
        req_ep <= ep;
        req_npkt <= n;
        @(negedge clk_i);
        while (!req_ready && t < 40) begin
            @(negedge clk_i);
            t++;
        end
        @(posedge clk_i);
        req_valid <= 1'b0;
        @(negedge clk_i);
        while (!rsp_valid && t < 80) begin
            @(negedge clk_i);
            t++;
        end
        // no answer at all must not pass on stale values
        if (t >= 80) begin
            errors++;
            $display("BAD answer expected 1 seen 0");
        end
        chk("code", 16'(c), 16'(rsp_code));
        chk("vec", 16'(v), 16'(rsp_vec));
    endtask

    // open a slot every fourth cycle until the host reports a message
    task automatic note(input logic [15:0] eps, input logic enc);
        int k;
        k = 0;
        while (k < 60) begin
            @(posedge clk_i);
            device_notify_time_slot <= (k % 4 == 0);
            @(negedge clk_i);
            k = ntf_seen ? 99 : k + 1;
        end
        @(posedge clk_i);
        device_notify_time_slot <= 1'b0;
        @(negedge clk_i);
        chk("seen", 16'h0063, 16'(k));
        chk("eps", eps, link.ntf_eps);
        chk("enc", 16'(enc), 16'(link.ntf_enc));
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang is cut off well past the hundred or so cycles the tests take
    initial begin
        repeat (4000) @(posedge clk_i);
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("active", 16'hFFFF, active);
        xfer(EFCN_TK_OUT, 4'h1, 8'h03, EFCN_HS_ACK, 8'h1F);
        chk("count", 16'h0003, 16'(rx_count));
        lvl(1, 8'h02);
        xfer(EFCN_TK_OUT, 4'h1, 8'h02, EFCN_HS_ACK, 8'h00);
        chk("fc", 16'h0002, ep_fc);
        chk("active", 16'hFFFD, active);
        lvl(1, 8'h00);
        xfer(EFCN_TK_HSRQ, 4'h1, 8'h00, EFCN_HS_ACK, 8'h00);
        xfer(EFCN_TK_OUT, 4'h5, 8'h02, EFCN_HS_NAK, 8'h00);
        xfer(EFCN_TK_HSRQ, 4'h5, 8'h00, EFCN_HS_NAK, 8'h00);
        // inactive iso endpoint is reached by an in token only in its scheduled slot
        @(posedge clk_i);
        req_periodic <= 1'b1;
        xfer(EFCN_TK_IN, 4'h5, 8'h00, EFCN_HS_NAK, 8'h00);
        lvl(5, 8'h03);
        req_periodic <= 1'b0;
        xfer(EFCN_TK_HSRQ, 4'h5, 8'h00, EFCN_HS_ACK, 8'h07);
        repeat (3) @(negedge clk_i);
        chk("busy", 16'h0000, 16'(ntf_busy));
        xfer(EFCN_TK_IN, 4'h2, 8'h00, EFCN_HS_NAK, 8'h00);
        lvl(4, 8'h01);
        xfer(EFCN_TK_OUT, 4'h4, 8'h01, EFCN_HS_ACK, 8'h00);
        // three endpoints become ready in the same cycle
        @(posedge clk_i);
        ep_level[39:0] <= 40'h02_0001_0400;
        note(16'h0006, 1'b0);
        note(16'h0010, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("fc", 16'h0000, ep_fc & 16'h0016);
        xfer(EFCN_TK_IN, 4'h2, 8'h00, EFCN_HS_ACK, 8'h00);
        lvl(2, 8'h00);
        xfer(EFCN_TK_IN, 4'h2, 8'h00, EFCN_HS_NAK, 8'h00);
        @(posedge clk_i);
        cfg_event <= 1'b1;
        @(posedge clk_i);
        cfg_event <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("fc", 16'h0000, ep_fc);
        chk("active", 16'hFFFF, active);
        chk("take", 16'h0004, 16'(n_take));
        results();
    end
endmodule
`default_nettype wire
